// file: inc/pec_regs.vh
`ifndef PEC_REGS_VH
`define PEC_REGS_VH
// character codes
`define PEC_CH_DLE      8'h10
`define PEC_CH_CR       8'h0D
`define PEC_CH_PLUS     8'h2B
`define PEC_CH_PROMPT   8'h40
`define PEC_CH_BS       8'h08
`define PEC_CH_CAN      8'h18
`define PEC_CH_C        8'h43
`define PEC_CH_L        8'h4C
`define PEC_CH_R        8'h52
// service signal codes on svc_code_o
`define PEC_SVC_NONE    3'h0
`define PEC_SVC_COM     3'h1
`define PEC_SVC_CLRCONF 3'h2
`define PEC_SVC_CLRCAUS 3'h3
`define PEC_SVC_PROMPT  3'h4
`define PEC_SVC_CMD     3'h5
// command buffer depth
`define PEC_CMD_DEPTH   16
`endif

// file: design/pec_cmd_buf.v
`timescale 1ns/1ps
`include "pec_regs.vh"
module pec_cmd_buf #(
  parameter DEPTH = `PEC_CMD_DEPTH,
  parameter AW    = 4
) (
  // clock and reset
  input  wire          sys_clk_i,
  input  wire          reset_n_i,
  // control
  input  wire          push_i,
  input  wire [7:0]    push_data_i,
  input  wire          del_char_i,
  input  wire          del_line_i,
  // state
  output reg  [AW:0]   count_o,
  output wire          is_clr_o
);
  reg [7:0] mem_r [0:DEPTH-1];

  // stored text equals CLR
  assign is_clr_o = (count_o == 3) && (mem_r[0] == `PEC_CH_C) &&
                    (mem_r[1] == `PEC_CH_L) && (mem_r[2] == `PEC_CH_R);

  always @(posedge sys_clk_i)
  begin
    if (push_i && (count_o < DEPTH))
      mem_r[count_o[AW-1:0]] <= push_data_i;
  end

  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      count_o <= {(AW+1){1'b0}};
    else if (del_line_i)
      count_o <= {(AW+1){1'b0}};
    else if (del_char_i && (count_o != 0))
      count_o <= count_o - 1'b1;
    else if (push_i && (count_o < DEPTH))
      count_o <= count_o + 1'b1;
  end
endmodule // pec_cmd_buf

// file: design/pec_escape_ctrl.v
`timescale 1ns/1ps
`include "pec_regs.vh"
// Function
// - on setup send COM, then host data
// - clear accepted only after data transfer
// - escape character enters command state
// - forward pending data and send prompt in the same cycle
// - CLR plus CR clears, confirms, prompts
// - first CR or plus resumes data
// - second escape stores one escape as data
// - other characters buffered until terminator
// - session end also clears the circuit
// - command state passes nothing to remote except the doubled escape
// - every command except a selection answered with service signal
// - failed circuit gives cause, early clear gets command signal
// - parameter six zero suppresses service signals
// - selection loads working profile parameters
module pec_escape_ctrl (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       reset_n_i,
  // configuration
  input  wire [7:0] esc_char_i,
  input  wire       esc_enable_i,
  input  wire [7:0] char_del_i,
  input  wire [7:0] line_del_i,
  input  wire       svc_enable_i,
  // terminal input
  input  wire       term_valid_i,
  input  wire [7:0] term_data_i,
  // circuit events
  input  wire       circuit_up_i,
  input  wire       circuit_fail_i,
  input  wire [3:0] fail_cause_i,
  input  wire       session_end_i,
  input  wire       pending_data_i,
  // remote direction
  output reg        remote_valid_o,
  output reg  [7:0] remote_data_o,
  output reg        forward_o,
  output reg        clear_req_o,
  output reg        select_o,
  output reg        load_profile_o,
  // service signals
  output reg        svc_valid_o,
  output reg  [2:0] svc_code_o,
  output reg  [3:0] svc_cause_o,
  output reg        cmd_valid_o,
  // state
  output reg        data_state_o,
  output reg        connected_o
);
  localparam ST_CMD  = 2'd0;
  localparam ST_DATA = 2'd1;
  localparam ST_ESC1 = 2'd2;
  localparam ST_ESCB = 2'd3;

  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  wire [4:0] buf_count;
  wire       buf_is_clr;
  wire       is_term;
  wire       is_del;
  wire       is_kill;
  wire       svc_ok;
  reg        push;
  reg        prompt_due_r;
  wire       clr_hit;
  wire       sel_hit;

  assign is_term = (term_data_i == `PEC_CH_CR) || (term_data_i == `PEC_CH_PLUS);
  assign is_del  = term_data_i == char_del_i;
  assign is_kill = term_data_i == line_del_i;
  assign svc_ok  = svc_enable_i;
  assign clr_hit = buf_is_clr && connected_o && (state_r == ST_ESCB);
  assign sel_hit = (state_r == ST_CMD) && !connected_o && (buf_count != 0) && !buf_is_clr;

  always @*
  begin
    push = 1'b0;
    if (term_valid_i && !is_term && !is_del && !is_kill)
      push = (state_r == ST_CMD) || (state_r == ST_ESCB) ||
             ((state_r == ST_ESC1) && (term_data_i != esc_char_i));
  end

  pec_cmd_buf #(
    .DEPTH (`PEC_CMD_DEPTH),
    .AW    (4)
  ) u_buf (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .push_i      (push),
    .push_data_i (term_data_i),
    .del_char_i  (term_valid_i && is_del && (state_r != ST_DATA)),
    .del_line_i  ((term_valid_i && is_kill && (state_r != ST_DATA)) ||
                  (term_valid_i && is_term && (state_r != ST_DATA))),
    .count_o     (buf_count),
    .is_clr_o    (buf_is_clr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state, same priority as the output process
  always @*
  begin
    state_nxt = state_r;
    if (circuit_fail_i)
      state_nxt = ST_CMD;
    else if (circuit_up_i && !connected_o)
      state_nxt = ST_DATA;
    else if (session_end_i && connected_o)
      state_nxt = ST_CMD;
    else if (term_valid_i)
    begin
      case (state_r)
        ST_DATA:
          if (esc_enable_i && (term_data_i == esc_char_i))
            state_nxt = ST_ESC1;
        ST_ESC1:
          if (is_term || (term_data_i == esc_char_i))
            state_nxt = ST_DATA;
          else if (!is_del && !is_kill)
            state_nxt = ST_ESCB;
        ST_ESCB, ST_CMD:
          if (is_term)
          begin
            if (clr_hit)
              state_nxt = ST_CMD;
            else if (!sel_hit)
              state_nxt = connected_o ? ST_DATA : ST_CMD;
          end
        default:
          state_nxt = ST_CMD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r        <= ST_CMD;
      prompt_due_r   <= 1'b0;
      remote_valid_o <= 1'b0;
      remote_data_o  <= 8'h00;
      forward_o      <= 1'b0;
      clear_req_o    <= 1'b0;
      select_o       <= 1'b0;
      load_profile_o <= 1'b0;
      svc_valid_o    <= 1'b0;
      svc_code_o     <= `PEC_SVC_NONE;
      svc_cause_o    <= 4'h0;
      cmd_valid_o    <= 1'b0;
      data_state_o   <= 1'b0;
      connected_o    <= 1'b0;
    end
    else
    begin
      remote_valid_o <= 1'b0;
      forward_o      <= 1'b0;
      clear_req_o    <= 1'b0;
      select_o       <= 1'b0;
      load_profile_o <= 1'b0;
      prompt_due_r   <= 1'b0;
      // prompt that follows a clear confirmation
      svc_valid_o    <= svc_ok && prompt_due_r;
      svc_code_o     <= prompt_due_r ? `PEC_SVC_PROMPT : `PEC_SVC_NONE;
      cmd_valid_o    <= 1'b0;
      if (circuit_fail_i)
      begin
        connected_o <= 1'b0;
        svc_valid_o <= svc_ok;
        svc_code_o  <= `PEC_SVC_CLRCAUS;
        svc_cause_o <= fail_cause_i;
      end
      else if (circuit_up_i && !connected_o)
      begin
        connected_o <= 1'b1;
        svc_valid_o <= svc_ok;
        svc_code_o  <= `PEC_SVC_COM;
      end
      else if (session_end_i && connected_o)
      begin
        connected_o <= 1'b0;
        clear_req_o <= 1'b1;
      end
      else if (term_valid_i)
      begin
        case (state_r)
          ST_DATA:
            if (esc_enable_i && (term_data_i == esc_char_i))
            begin
              forward_o   <= pending_data_i;
              svc_valid_o <= svc_ok;
              svc_code_o  <= `PEC_SVC_PROMPT;
            end
            else
            begin
              remote_valid_o <= 1'b1;
              remote_data_o  <= term_data_i;
            end
          ST_ESC1:
            if (!is_term && (term_data_i == esc_char_i))
            begin
              remote_valid_o <= 1'b1;
              remote_data_o  <= esc_char_i;
            end
          ST_ESCB, ST_CMD:
            if (is_term)
            begin
              if (clr_hit)
              begin
                clear_req_o  <= 1'b1;
                connected_o  <= 1'b0;
                prompt_due_r <= 1'b1;
                svc_valid_o  <= svc_ok;
                svc_code_o   <= `PEC_SVC_CLRCONF;
              end
              else if (sel_hit)
              begin
                select_o       <= 1'b1;
                load_profile_o <= 1'b1;
              end
              else
              begin
                cmd_valid_o <= 1'b1;
                svc_valid_o <= svc_ok;
                svc_code_o  <= `PEC_SVC_CMD;
              end
            end
          default:
            remote_valid_o <= 1'b0;
        endcase
      end
      state_r      <= state_nxt;
      data_state_o <= (state_nxt == ST_DATA);
    end
  end
endmodule // pec_escape_ctrl

// file: testbench/pec_props_properties.sv
`timescale 1ns/1ps
module pec_props (
  // clock and reset
  input wire       sys_clk_i, reset_n_i,
  // inputs
  input wire [7:0] esc_char_i, term_data_i,
  input wire       esc_enable_i, svc_enable_i, term_valid_i,
  input wire       circuit_up_i, circuit_fail_i, session_end_i,
  input wire [3:0] fail_cause_i,
  // outputs
  input wire       remote_valid_o, clear_req_o, svc_valid_o,
  input wire       data_state_o, connected_o,
  input wire [7:0] remote_data_o,
  input wire [2:0] svc_code_o,
  input wire [3:0] svc_cause_o
);
  wire [7:0] d   = term_data_i;
  wire       ch  = term_valid_i && !circuit_fail_i && !circuit_up_i && !session_end_i;
  wire       esc = ch && esc_enable_i && d == esc_char_i;
  wire       cr  = ch && d == 8'h0D;
  reg        escd_r;
  wire       just = escd_r && !data_state_o;
  // escape taken in data state one cycle ago
  always @(posedge sys_clk_i or negedge reset_n_i)
    if (!reset_n_i)
      escd_r <= 1'b0;
    else
      escd_r <= esc && data_state_o;
  ////////////////////////////////////////
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_esc_enter: assert property (data_state_o && esc |=> !data_state_o)
    else $error("escape did not leave data state");
  a_esc_prompt: assert property (data_state_o && esc |=>
    $past(svc_enable_i) == (svc_valid_o && svc_code_o == 3'h4)) else $error("no prompt");
  a_first_term: assert property (just && cr |=> data_state_o)
    else $error("terminator did not resume data");
  a_dbl_esc: assert property (just && esc |=> data_state_o && remote_valid_o
    && remote_data_o == $past(esc_char_i)) else $error("second escape not stored");
  a_clr_cmd: assert property (just && connected_o && ch && d == 8'h43 ##1 ch && d == 8'h4C
    ##1 ch && d == 8'h52 ##1 cr |=> clear_req_o) else $error("clear not issued");
  a_svc_gate: assert property (!$past(svc_enable_i) |-> !svc_valid_o)
    else $error("service signal not suppressed");
  a_fail_cause: assert property (circuit_fail_i && svc_enable_i |=> svc_valid_o
    && svc_code_o == 3'h3 && svc_cause_o == $past(fail_cause_i)) else $error("bad cause");
  a_sess_clr: assert property (session_end_i && connected_o && !circuit_fail_i
    |=> clear_req_o) else $error("session end did not clear");
  cover property (just && cr);
  cover property (just && esc);
  cover property (session_end_i && connected_o);
endmodule // pec_props

// file: testbench/pec_term_model.sv
`timescale 1ns/1ps
module pec_term_model (
  // link to block
  input  wire       sys_clk_i,
  output reg        valid_o,
  output reg  [7:0] data_o
);
  initial
  begin
    valid_o = 1'b0;
    data_o  = 8'h00;
  end
  // one char per cycle, back to back allowed
  task send(input [7:0] c);
    @(posedge sys_clk_i);
    #1 valid_o = 1'b1;
    data_o = c;
  endtask
  // released line shows inverse of last value
  task idle;
    @(posedge sys_clk_i);
    #1 valid_o = 1'b0;
    data_o = ~data_o;
  endtask
endmodule // pec_term_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg        sys_clk_i, reset_n_i, svc_enable_i, pending_data_i;
  reg        circuit_up_i, circuit_fail_i, session_end_i;
  reg  [3:0] fail_cause_i;
  wire       term_valid_i, remote_valid_o, forward_o, clear_req_o, select_o;
  wire       load_profile_o, svc_valid_o, cmd_valid_o, data_state_o, connected_o;
  wire [7:0] term_data_i, remote_data_o;
  wire [2:0] svc_code_o;
  wire [3:0] svc_cause_o;
  reg  [7:0] esc_char_i, char_del_i, line_del_i;
  reg        esc_enable_i;
  integer    num_errors = 0, n_tests = 0, seed = 57, r;
  reg  [7:0] sq[$], rq[$], cq[$];
  always #5 sys_clk_i = ~sys_clk_i;
  pec_term_model u_term (.sys_clk_i(sys_clk_i), .valid_o(term_valid_i), .data_o(term_data_i));
  pec_escape_ctrl DUT (.*);
  ////////////////////////////////////////
  task cmp(input string nm, input [7:0] e, input [7:0] g);
    n_tests++;
    if (e !== g)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task say(input string s);
    for (int i = 0; i < s.len(); i++) u_term.send(s[i]);
    u_term.idle();
  endtask
  task pulse(input [2:0] k);
    {session_end_i, circuit_fail_i, circuit_up_i} = k;
    @(posedge sys_clk_i);
    #1 {session_end_i, circuit_fail_i, circuit_up_i} = 3'h0;
  endtask
  task conclude;
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(negedge sys_clk_i)
  begin
    if (svc_valid_o === 1'b1)
      cmp("svc", sq.size() ? sq.pop_front() : 8'hXX,
          {1'b0, svc_code_o, svc_code_o == 3'h3 ? svc_cause_o : 4'h0});
    if (remote_valid_o === 1'b1)
      cmp("remote", rq.size() ? rq.pop_front() : 8'hXX, remote_data_o);
    if ((select_o | clear_req_o | forward_o | cmd_valid_o) === 1'b1)
      cmp("ctl", cq.size() ? cq.pop_front() : 8'hXX,
          {3'h0, cmd_valid_o, select_o, load_profile_o, clear_req_o, forward_o});
  end
  initial
  begin
    #50000 num_errors++;
    conclude;
  end
  initial
  begin
    {sys_clk_i, reset_n_i, svc_enable_i, pending_data_i} = 4'h0;
    {circuit_up_i, circuit_fail_i, session_end_i, fail_cause_i} = 7'h00;
    {esc_char_i, char_del_i, line_del_i, esc_enable_i} = {8'h10, 8'h08, 8'h18, 1'b1};
    repeat (6) @(posedge sys_clk_i);
    #1 reset_n_i = 1'b1;
    cq.push_back(8'h10);
    say("\015");
    cq.push_back(8'h10);
    cq.push_back(8'h10);
    say("Y\030\015#\010\015");
    svc_enable_i = 1'b1;
    cq.push_back(8'h0C);
    say("#A\015");
    sq.push_back(8'h10);
    pulse(3'h1);
    r = $random(seed);
    rq.push_back(r[7:0] | 8'h20);
    u_term.send(r[7:0] | 8'h20);
    u_term.idle();
    pending_data_i = 1'b1;
    cq.push_back(8'h01);
    sq.push_back(8'h40);
    say("\020\015");
    pending_data_i = 1'b0;
    sq.push_back(8'h40);
    rq.push_back(8'h10);
    say("\020\020");
    sq.push_back(8'h40);
    cq.push_back(8'h02);
    sq.push_back(8'h20);
    sq.push_back(8'h40);
    say("\020CLR\015");
    @(posedge sys_clk_i);
    #1 r = $random(seed);
    fail_cause_i = r[3:0];
    sq.push_back({4'h3, r[3:0]});
    pulse(3'h2);
    sq.push_back(8'h10);
    pulse(3'h1);
    esc_enable_i = 1'b0;
    rq.push_back(8'h10);
    say("\020");
    esc_enable_i = 1'b1;
    svc_enable_i = 1'b0;
    cq.push_back(8'h02);
    pulse(3'h4);
    repeat (5) @(posedge sys_clk_i);
    cmp("left", 8'h00, sq.size() + rq.size() + cq.size());
    conclude;
  end
endmodule // testbench
bind pec_escape_ctrl pec_props u_props (.*);
